// [src/asd_pkg.sv]
// Package for the address space decoder: address windows, layout constants, carrier structs.
// Assumes a 32-bit signed address space with byte addresses from the core.
package asd_pkg;

  localparam int          ADDR_W          = 32;
  localparam int          DATA_W          = 32;
  localparam int          BANK_CNT        = 4;
  localparam int          BANK_SEL_W      = 2;
  localparam int          PERIPH_OFF_W    = 12;
  localparam int          PERIPH_IDX_W    = 4;
  localparam int          SRAM_BYTES      = 16384;
  localparam int          SRAM_ADDR_W     = 14;
  localparam int          MUX_HALF_W      = 16;
  localparam int          TIMING_W        = 8;
  localparam int          TYPE_W          = 2;
  localparam int          WIDTH_CFG_W     = 2;
  localparam logic [7:0]  PHASES_PER_CYCLE    = 8'h02;

  // Signed lowest address and derived internal windows
  localparam logic [31:0] LOWEST_ADDRESS      = 32'h8000_0000;
  localparam logic [31:0] SRAM_LIMIT          = 32'h8000_4000;
  localparam logic [31:0] TRAP_AREA_BASE      = 32'h8000_0040;
  localparam logic [31:0] USER_MEMORY_START   = 32'h8000_0140;
  localparam logic [31:0] LINK_IN_BASE        = 32'h8000_0010;
  localparam logic [31:0] EVENT_CHAN_ADDR     = 32'h8000_0020;
  localparam logic [31:0] BOOT_ENTRY_POINT    = 32'h7fff_fffe;
  localparam logic [31:0] PERIPH_BASE         = 32'h2000_0000;
  localparam logic [31:0] PERIPH_LIMIT        = 32'h4000_0000;
  localparam logic [31:0] TRAP_STRUCT_BYTES   = 32'h0000_0010;

  // Peripheral block indices inside the window
  localparam logic [3:0]  PERIPH_IRQ_CTRL     = 4'h0;
  localparam logic [3:0]  PERIPH_LOW_POWER    = 4'h1;
  localparam logic [3:0]  PERIPH_EXT_MEM_CTRL = 4'h2;
  localparam logic [3:0]  PERIPH_DIAG         = 4'h3;

  // Bank memory type and width encodings
  localparam logic [1:0]  MEM_TYPE_SRAM       = 2'h0;
  localparam logic [1:0]  MEM_TYPE_DRAM       = 2'h1;
  localparam logic [1:0]  MEM_TYPE_ROM        = 2'h2;
  localparam logic [1:0]  MEM_TYPE_IO         = 2'h3;
  localparam logic [1:0]  BUS_W32             = 2'h0;
  localparam logic [1:0]  BUS_W16             = 2'h1;
  localparam logic [1:0]  BUS_W8              = 2'h2;

  // Access size encodings
  localparam logic [1:0]  SIZE_BYTE           = 2'h0;
  localparam logic [1:0]  SIZE_HALF           = 2'h1;
  localparam logic [1:0]  SIZE_WORD           = 2'h2;

  typedef struct packed {
    logic        valid;
    logic        device_op;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } asd_req_s;

  typedef struct packed {
    logic [7:0]  setup_phases;
    logic [7:0]  strobe_phases;
    logic [1:0]  mem_type;
    logic [1:0]  bus_width;
  } asd_bank_cfg_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  bank;
    logic        multiplexed;
    logic        row_phase;
    logic [29:0] ext_address_bus;
    logic [1:0]  byte_sel;
    logic [3:0]  byte_en;
    logic [31:0] ext_data_bus;
    logic [7:0]  phase_count;
    logic [1:0]  bus_width;
  } asd_ext_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  block;
    logic [11:0] offset;
    logic [31:0] wdata;
  } asd_per_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [13:0] offset;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } asd_sram_s;

endpackage

// [src/asd_decoder.sv]
// Address space decoder: steers each core access to SRAM, peripherals or an external bank.
// Assumes the core holds a request until accepted, and one request at a time.
`timescale 1ns/1ps

// Summary of operation
// - Device ops in peripheral window reach peripherals
// - Device ops elsewhere behave as memory accesses
// - Ordinary loads/stores in window go external
// - Window split into 4K peripheral blocks
// - 16K SRAM mapped from lowest address upward
// - SRAM wins over overlapping external memory
// - Disable pin sends SRAM range external
// - Pin low: SRAM range never external
// - Four equal external banks, no range check
// - Per-bank timing and type applied per access
// - External interface spans 4 gigabyte space
// - SRAM: channels, traps, then user memory
// - Trap area holds 16-byte structures per group
// - Channel words: outputs, inputs, event channel
// - Word addressing with byte/part-word support
// - External timing counted in half-cycle phases
// - Data LSB always on data line zero
// - DRAM banks get row/column multiplexed address
module asd_decoder
  import asd_pkg::*;
#(
  parameter int PERIPH_BLOCKS = 16
) (
  input  wire logic                   core_clk,         // Processor clock, 50 MHz
  input  wire logic                   arst_n,           // Async reset, active low
  input  wire asd_req_s               core_req,         // Core access request
  output logic                        core_ready,       // SRAM or peripheral request accepted this cycle
  input  wire logic                   internal_ram_disable_pin, // High disables SRAM
  input  wire asd_bank_cfg_s [3:0]    bank_cfg,         // Per-bank timing and type
  input  wire logic                   ext_done,         // External access finished
  input  wire logic                   per_ready,        // Peripheral accepts access
  output asd_sram_s                   sram_out,         // Internal SRAM access
  output asd_per_s                    per_out,          // Peripheral access
  output logic [PERIPH_BLOCKS-1:0]    per_sel,          // One-hot peripheral select
  output asd_ext_s                    ext_out,          // External memory access
  output logic                        trap_area_hit,    // Access lies in trap area
  output logic                        chan_area_hit,    // Access lies in channel words
  output logic                        user_area_hit     // Access at or above user start
);

  typedef enum logic [2:0] {
    ASD_IDLE = 3'b001,
    ASD_ROW  = 3'b010,
    ASD_COL  = 3'b100
  } asd_state_e;

  function automatic logic [3:0] asd_byte_en(input logic [1:0] size, input logic [1:0] lo);
    case (size)
      SIZE_BYTE: asd_byte_en = 4'h1 << lo;
      SIZE_HALF: asd_byte_en = lo[1] ? 4'hc : 4'h3;
      default:   asd_byte_en = 4'hf;
    endcase
  endfunction

  function automatic logic asd_in_range(input logic [31:0] a, input logic [31:0] lo,
                                        input logic [31:0] hi);
    asd_in_range = (a >= lo) && (a < hi);
  endfunction

  logic       rst_sync1_ff;
  logic       rst_sync2_ff;
  logic       ram_dis_s1_ff;
  logic       ram_dis_s2_ff;
  asd_state_e state_ff;
  asd_state_e nxt_state;
  asd_ext_s   ext_ff;
  asd_ext_s   nxt_ext;
  asd_sram_s  sram_ff;
  asd_per_s   per_ff;
  logic [PERIPH_BLOCKS-1:0] per_sel_ff;
  logic [2:0] area_ff;
  logic [7:0] phase_ff;
  logic [7:0] nxt_phase;

  wire rst_n = rst_sync2_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end

  // Disable pin is asynchronous to the core clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_dis_s1_ff <= 1'b0;
      ram_dis_s2_ff <= 1'b0;
    end else begin
      ram_dis_s1_ff <= internal_ram_disable_pin;
      ram_dis_s2_ff <= ram_dis_s1_ff;
    end
  end

  wire [31:0] addr      = core_req.addr;
  wire        in_sram   = asd_in_range(addr, LOWEST_ADDRESS, SRAM_LIMIT);
  wire        to_sram   = in_sram && !ram_dis_s2_ff;
  wire        in_periph = asd_in_range(addr, PERIPH_BASE, PERIPH_LIMIT);
  // Device op in window goes to peripherals
  wire        to_per    = core_req.device_op && in_periph && !to_sram;
  // Other device ops treated as memory
  // Plain loads in window stay external
  // Disabled SRAM falls through to external
  wire        to_ext    = !to_sram && !to_per;
  // Block from bits above 12-bit offset
  wire [PERIPH_IDX_W-1:0] per_idx = addr[PERIPH_OFF_W +: PERIPH_IDX_W];
  wire        per_valid = (32'(per_idx) < 32'(PERIPH_BLOCKS));
  // Top two bits choose the bank
  wire [BANK_SEL_W-1:0] bank = addr[ADDR_W-1 -: BANK_SEL_W];
  wire asd_bank_cfg_s cfg   = bank_cfg[bank];
  wire        is_mux    = (cfg.mem_type == MEM_TYPE_DRAM);
  // Byte lanes from size and low bits
  wire [3:0]  be        = asd_byte_en(core_req.size, addr[1:0]);

  // Regions split at trap area base and user memory start
  wire        chan_hit  = asd_in_range(addr, LOWEST_ADDRESS, TRAP_AREA_BASE);
  wire        trap_hit  = asd_in_range(addr, TRAP_AREA_BASE, USER_MEMORY_START);
  wire        user_hit  = asd_in_range(addr, USER_MEMORY_START, SRAM_LIMIT);

  wire        idle      = (state_ff == ASD_IDLE);
  wire        take      = core_req.valid && idle && (!to_per || per_ready);
  wire        phase_end = (phase_ff == 8'h00);

  assign core_ready = take && !to_ext;

  always_comb begin
    nxt_state = state_ff;
    nxt_ext   = ext_ff;
    nxt_phase = phase_ff;
    case (state_ff)
      ASD_IDLE: begin
        nxt_ext.valid = 1'b0;
        if (take && to_ext) begin
          nxt_ext.valid       = 1'b1;
          nxt_ext.write       = core_req.write;
          nxt_ext.bank        = bank;
          nxt_ext.multiplexed = is_mux;
          nxt_ext.bus_width   = cfg.bus_width;
          nxt_ext.byte_sel    = addr[1:0];
          nxt_ext.byte_en     = be;
          // LSB of data on line zero
          nxt_ext.ext_data_bus = core_req.wdata;
          // Row half first for multiplexed banks
          nxt_ext.row_phase   = is_mux;
          // Full 30-bit word address on plain banks, 4 GB; row half on multiplexed
          nxt_ext.ext_address_bus = is_mux ? {14'h0000, addr[ADDR_W-1 -: MUX_HALF_W]}
                                           : addr[ADDR_W-1:2];
          nxt_phase = 8'(cfg.setup_phases + cfg.strobe_phases);
          nxt_ext.phase_count = nxt_phase;
          nxt_state = is_mux ? ASD_ROW : ASD_COL;
        end
      end
      ASD_ROW: begin
        if (phase_end || phase_ff == 8'h01) begin
          nxt_ext.row_phase       = 1'b0;
          nxt_ext.ext_address_bus = {14'h0000, ext_ff.ext_address_bus[15:0] ^ 16'h0000};
          nxt_state = ASD_COL;
        end else begin
          nxt_phase = phase_ff - PHASES_PER_CYCLE;
        end
      end
      ASD_COL: begin
        if (!phase_end)
          nxt_phase = (phase_ff > 8'h01) ? phase_ff - PHASES_PER_CYCLE : 8'h00;
        if (ext_done && phase_end) begin
          nxt_ext.valid = 1'b0;
          nxt_state = ASD_IDLE;
        end
      end
      default: nxt_state = ASD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ASD_IDLE;
      ext_ff   <= '0;
      phase_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      ext_ff   <= nxt_ext;
      phase_ff <= nxt_phase;
    end
  end

  // Column half kept for the second address beat
  logic [15:0] col_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      col_ff <= 16'h0000;
    end else if (take && to_ext) begin
      col_ff <= addr[MUX_HALF_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sram_ff    <= '0;
      per_ff     <= '0;
      per_sel_ff <= '0;
      area_ff    <= 3'h0;
    end else begin
      sram_ff.valid   <= take && to_sram;
      sram_ff.write   <= core_req.write;
      sram_ff.offset  <= addr[SRAM_ADDR_W-1:0];
      sram_ff.byte_en <= be;
      sram_ff.wdata   <= core_req.wdata;
      per_ff.valid    <= take && to_per && per_valid;
      per_ff.write    <= core_req.write;
      per_ff.block    <= per_idx;
      per_ff.offset   <= addr[PERIPH_OFF_W-1:0];
      per_ff.wdata    <= core_req.wdata;
      per_sel_ff      <= (take && to_per && per_valid) ?
                         PERIPH_BLOCKS'(1) << per_idx : '0;
      area_ff         <= (take && to_sram) ? {user_hit, trap_hit, chan_hit} : 3'h0;
    end
  end

  always_comb begin
    ext_out = ext_ff;
    if (ext_ff.valid && ext_ff.multiplexed && !ext_ff.row_phase)
      ext_out.ext_address_bus = {14'h0000, col_ff};
  end

  assign sram_out      = sram_ff;
  assign per_out       = per_ff;
  assign per_sel       = per_sel_ff;
  assign chan_area_hit = area_ff[0];
  assign trap_area_hit = area_ff[1];
  assign user_area_hit = area_ff[2];

  sequence s_sram_req;
    core_req.valid && idle && in_sram && !ram_dis_s2_ff;
  endsequence

  sequence s_ext_take;
    take && to_ext;
  endsequence

  sequence s_row_open;
    ext_out.valid && ext_out.row_phase;
  endsequence

  a_sram_route: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_sram_req |=> sram_out.valid) else $error("SRAM access not routed to SRAM");
  // No external access in SRAM range
  a_sram_no_ext: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_sram_req |=> !ext_out.valid) else $error("External access in SRAM range");
  // Device op in SRAM stays internal
  a_sram_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && to_sram && core_req.device_op |=> sram_out.valid && !per_out.valid)
    else $error("SRAM access left SRAM");
  // Device op in window to diag block reaches peripheral 3
  a_per_route: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && core_req.device_op && in_periph && !to_sram && per_idx == PERIPH_DIAG
    |=> per_sel[3] && per_out.valid) else $error("Peripheral select wrong");
  a_per_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    core_req.valid && idle && to_per && !per_ready |=> !per_out.valid)
    else $error("Peripheral access while not ready");
  // Block and offset from the address
  a_per_block: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && to_per && per_valid |=> per_out.block == $past(per_idx)
    && per_out.offset == $past(addr[PERIPH_OFF_W-1:0]) && $onehot(per_sel))
    else $error("Peripheral block wrong");
  // Device op outside window is memory
  a_dev_mem: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && core_req.device_op && !in_periph && !to_sram |=> ext_out.valid && !per_out.valid)
    else $error("Device op outside window misrouted");
  // Plain access in window goes external
  a_plain_ext: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && !core_req.device_op && in_periph |=> ext_out.valid && !per_out.valid)
    else $error("Plain access reached peripheral");
  a_bank_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_ext_take |=> ext_out.bank == $past(addr[ADDR_W-1 -: BANK_SEL_W]))
    else $error("Bank select wrong");
  a_bank_cfg: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_ext_take |=> ext_out.bus_width == $past(cfg.bus_width)
    && ext_out.multiplexed == $past(is_mux)) else $error("Bank settings wrong");
  // Bank and settings held in flight
  a_ext_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    ext_out.valid ##1 ext_out.valid |-> $stable(ext_out.bank) && $stable(ext_out.bus_width)
    && !core_ready) else $error("External access disturbed in flight");
  // Full word address on plain banks
  a_word_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && to_ext && !is_mux |=> ext_out.ext_address_bus == $past(addr[ADDR_W-1:2]))
    else $error("External word address wrong");
  a_data_lsb: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_ext_take |=> ext_out.ext_data_bus == $past(core_req.wdata))
    else $error("External data lanes wrong");
  a_phase_load: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_ext_take |=> ext_out.phase_count == $past(8'(cfg.setup_phases + cfg.strobe_phases)))
    else $error("Phase count wrong");
  a_ram_dis: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && in_sram && ram_dis_s2_ff |=> ext_out.valid && !sram_out.valid)
    else $error("Disabled SRAM still used");
  a_mux_row: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && to_ext && is_mux |=> ext_out.row_phase && ext_out.multiplexed)
    else $error("Row phase missing");
  // Row half gives way to column
  a_row_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_row_open |-> ##[1:130] !ext_out.row_phase) else $error("Row phase never ended");
  a_user_area: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && to_sram && addr >= USER_MEMORY_START |=> user_area_hit && !trap_area_hit)
    else $error("User region flag wrong");
  a_trap_area: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && to_sram && addr >= TRAP_AREA_BASE && addr < USER_MEMORY_START |=> trap_area_hit)
    else $error("Trap region flag wrong");
  a_chan_area: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && to_sram && addr < TRAP_AREA_BASE |=> chan_area_hit && !trap_area_hit)
    else $error("Channel region flag wrong");
  // Byte access enables a single lane
  a_byte_lane: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && to_sram && core_req.size == SIZE_BYTE |=> $onehot(sram_out.byte_en))
    else $error("Byte lane wrong");
  a_half_lane: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && to_sram && core_req.size == SIZE_HALF
    |=> sram_out.byte_en == ($past(addr[1]) ? 4'hc : 4'h3)) else $error("Half lanes wrong");

endmodule

// [test/asd_core_model.sv]
// Core-side partner: issues one access at a time and plays the slow or prompt far side.
// Assumes the decoder contract: accept on core_ready, external completion on ext_out.valid.
`timescale 1ns/1ps

module asd_core_model
  import asd_pkg::*;
(
  input  wire logic     core_clk,   // Processor clock
  output asd_req_s      core_req,   // Request to the decoder
  input  wire logic     core_ready, // Accept strobe
  input  wire asd_ext_s ext_out,    // External access in flight
  output logic          ext_done,   // External side may finish
  output logic          per_ready   // Peripheral side can take
);
  logic took_ff;

  initial begin
    core_req  = '0;
    ext_done  = 1'b0;
    per_ready = 1'b1;
  end

  // Value of the accept strobe just before each edge
  always @(posedge core_clk) took_ff <= core_ready;

  // Far side answers promptly or slowly at random
  always @(negedge core_clk) begin
    ext_done  <= ($urandom % 3) != 0;
    per_ready <= ($urandom % 4) != 0;
  end

  task automatic send(input asd_req_s req);
    asd_req_s idle;
    logic     went_ext;
    int       n;
    went_ext = 1'b0;
    n = 0;
    @(negedge core_clk);
    core_req <= req;
    do begin
      @(posedge core_clk);
      #1;
      went_ext = ext_out.valid === 1'b1;
      n++;
    end while (took_ff !== 1'b1 && !went_ext && n < 64);
    // Released lines carry garbage, not the last value
    idle = req;
    idle.valid = 1'b0;
    idle.addr  = ~req.addr;
    idle.wdata = ~req.wdata;
    @(negedge core_clk);
    core_req <= idle;
    while (went_ext && ext_out.valid === 1'b1 && n < 256) begin
      @(negedge core_clk);
      n++;
    end
  endtask
endmodule

// [test/address_space_decoder_bench.sv]
// Self-checking bench for the address space decoder.
// Assumes the core partner model and a 50 MHz processor clock.
`timescale 1ns/1ps

module address_space_decoder_bench
  import asd_pkg::*;
;
  logic                 core_clk;
  logic                 arst_n;
  logic                 ram_off;
  asd_bank_cfg_s [3:0]  cfg;
  asd_req_s             core_req;
  logic                 core_ready;
  logic                 ext_done;
  logic                 per_ready;
  asd_sram_s            sram_out;
  asd_per_s             per_out;
  logic [15:0]          per_sel;
  asd_ext_s             ext_out;
  logic                 trap_area_hit;
  logic                 chan_area_hit;
  logic                 user_area_hit;
  logic [95:0]          q[$];
  logic                 ext_prev;
  logic                 row_prev;
  logic [31:0]          sram_pts [6] = '{32'h8000_0000, 32'h8000_0020, 32'h8000_0040,
                                         32'h8000_013c, 32'h8000_0140, 32'h8000_3ffc};
  int                   miscompares;
  int                   checked;
  int                   cycles;
  int                   i;
  logic [31:0]          a;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  asd_decoder #(.PERIPH_BLOCKS(16)) asd_decoder_inst (
    .core_clk(core_clk), .arst_n(arst_n), .core_req(core_req), .core_ready(core_ready),
    .internal_ram_disable_pin(ram_off), .bank_cfg(cfg), .ext_done(ext_done),
    .per_ready(per_ready), .sram_out(sram_out), .per_out(per_out), .per_sel(per_sel),
    .ext_out(ext_out), .trap_area_hit(trap_area_hit), .chan_area_hit(chan_area_hit),
    .user_area_hit(user_area_hit));

  asd_core_model asd_core_model_inst (
    .core_clk(core_clk), .core_req(core_req), .core_ready(core_ready),
    .ext_out(ext_out), .ext_done(ext_done), .per_ready(per_ready));

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic take(input logic [95:0] seen);
    if (q.size() == 0) begin
      miscompares++;
      $display("wrong value at %0t: unexpected access %h", $time, seen);
    end else
      check(seen, q.pop_front());
  endtask

  // Notes the expected routing, then has the core issue the access
  task automatic go(input logic dev, input logic wr, input logic [1:0] sz, input logic [31:0] ad);
    asd_req_s    r;
    logic [3:0]  be;
    logic [31:0] d;
    logic [1:0]  b;
    logic        mx;
    logic [7:0]  ph;
    d = $urandom;
    b = ad[31:30];
    mx = cfg[b].mem_type == MEM_TYPE_DRAM;
    be = sz == SIZE_WORD ? 4'hf : sz == SIZE_HALF ? (ad[1] ? 4'hc : 4'h3) : 4'h1 << ad[1:0];
    r = '{1'b1, dev, wr, sz, ad, d};
    if (dev && ad >= PERIPH_BASE && ad < PERIPH_LIMIT)
      q.push_back({ad[15:12], ad[11:0], 16'h0001 << ad[15:12], wr ? d : 32'h0, 2'd1});
    else if (!ram_off && ad >= LOWEST_ADDRESS && ad < SRAM_LIMIT)
      q.push_back({ad[13:0], be, ad >= TRAP_AREA_BASE && ad < USER_MEMORY_START,
                   ad < TRAP_AREA_BASE, ad >= USER_MEMORY_START, wr ? d : 32'h0, 2'd0});
    else begin
      ph = 8'(cfg[b].setup_phases + cfg[b].strobe_phases);
      q.push_back({b, mx, mx, mx ? {14'h0, ad[31:16]} : ad[31:2], cfg[b].bus_width, be,
                   ad[1:0], ph, wr ? d : 32'h0, 2'd2});
      if (mx)
        q.push_back({b, 2'b10, {14'h0, ad[15:0]}, cfg[b].bus_width, be,
                     ad[1:0], ph, wr ? d : 32'h0, 2'd2});
    end
    asd_core_model_inst.send(r);
  endtask

  task automatic test_end(input string name);
    for (int n = 0; n < 50 && q.size() != 0; n++)
      @(negedge core_clk);
    if (q.size() != 0) begin
      miscompares++;
      $display("wrong value at %0t: %0d results never seen", $time, q.size());
      q.delete();
    end
    $display("test %s ended, checks so far %0d", name, checked);
  endtask

  always @(negedge core_clk) begin
    if (arst_n === 1'b1) begin
      if (sram_out.valid === 1'b1)
        take({sram_out.offset, sram_out.byte_en, trap_area_hit, chan_area_hit, user_area_hit,
              sram_out.write ? sram_out.wdata : 32'h0, 2'd0});
      if (per_out.valid === 1'b1)
        take({per_out.block, per_out.offset, per_sel,
              per_out.write ? per_out.wdata : 32'h0, 2'd1});
      // Start of an access, and the column half of a multiplexed one
      if (ext_out.valid === 1'b1 && (!ext_prev || (row_prev && ext_out.row_phase === 1'b0)))
        take({ext_out.bank, ext_out.multiplexed, ext_out.row_phase, ext_out.ext_address_bus,
              ext_out.bus_width, ext_out.byte_en, ext_out.byte_sel, ext_out.phase_count,
              ext_out.write ? ext_out.ext_data_bus : 32'h0, 2'd2});
      ext_prev = ext_out.valid === 1'b1;
      row_prev = ext_prev && ext_out.row_phase === 1'b1;
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    miscompares = 0;
    checked = 0;
    cycles = 0;
    ext_prev = 1'b0;
    row_prev = 1'b0;
    arst_n = 1'b0;
    ram_off = 1'b0;
    void'($urandom(86));
    for (i = 0; i < 4; i++)
      cfg[i] = '{8'(2 + $urandom % 5), 8'(2 + $urandom % 5), 2'(i), 2'(i == 3 ? 0 : i)};
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    for (i = 0; i < 16; i++)
      go(1'b1, i[0], SIZE_WORD, 32'h2000_0000 | (i << 12) | ($urandom & 32'h0000_0ffc));
    go(1'b1, 1'b0, SIZE_WORD, 32'h3fff_fffc);
    test_end("peripheral blocks");
    go(1'b0, 1'b1, SIZE_WORD, 32'h2000_1000);
    go(1'b0, 1'b0, SIZE_WORD, 32'h2000_2000);
    go(1'b1, 1'b0, SIZE_WORD, 32'h4000_0000);
    test_end("window bypass");
    foreach (sram_pts[k])
      go(k[0], 1'b1, SIZE_WORD, sram_pts[k]);
    go(1'b0, 1'b0, SIZE_WORD, 32'h8000_4000);
    test_end("sram map");
    for (i = 0; i < 4; i++)
      go(1'b0, 1'b0, SIZE_BYTE, 32'h8000_0200 + i);
    go(1'b0, 1'b0, SIZE_HALF, 32'h8000_0200);
    go(1'b0, 1'b0, SIZE_HALF, 32'h8000_0202);
    test_end("part words");
    for (i = 0; i < 16; i++) begin
      a = {i[1:0], 30'($urandom)};
      if (i[1:0] == 2'd2)
        a[20] = 1'b1;
      go(i[1:0] != 2'd0 && i[2], i[1:0] == i[3:2] && i[1:0] != 2'd1 && i[1:0] != 2'd2,
         SIZE_WORD, a);
    end
    test_end("external banks");
    ram_off = 1'b1;
    repeat (4) @(negedge core_clk);
    go(1'b0, 1'b0, SIZE_WORD, 32'h8000_0100);
    go(1'b0, 1'b0, SIZE_WORD, 32'h8000_3ffc);
    ram_off = 1'b0;
    repeat (4) @(negedge core_clk);
    go(1'b1, 1'b1, SIZE_WORD, 32'h8000_0100);
    test_end("sram disable");
    test_done();
  end
endmodule
